// File: hdl/cvt_regs.v
// top of the calibration vector and trim register bank, AHB-Lite slave.
// assumes fuse trim inputs are stable while rst is high and that the
// calibration engine drives calib_halted_flag.
//
// Summary of operation
// RL1 - with access enabled, each port read returns the next calibration vector byte
// RL2 - host reads the port 673 times in a row for the whole vector
// RL3 - host writes 673 saved bytes in order; each loads the next vector slot
// RL4 - with address hold set, streaming addresses stay on the calibration port
// RL5 - host touches the port only while calibration is halted; else it corrupts
// RL6 - a sequence stopped short of 673 accesses marks the vector invalid
// RL7 - port is an 8-bit read/write field in bits 7:0, undefined before use
// RL8 - channel A gain trim: 8 bits, factory value at reset, read/write
// RL9 - channel B gain trim: 8 bits, factory value at reset, read/write
// RL10 - band-gap trim: 4 bits in 3:0, factory value at reset, 7:4 reserved
// RL11 - channel A termination trim: 8 bits, factory value at reset, read/write
// RL12 - port reaches the vector only after the enable bit at 0x70 is set
// RL13 - vector index clears on enable, steps once per access, wraps after last
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/1ns
`include "cvt_defines.vh"

module cvt_regs (
  input wire clk,
  input wire rst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire [2:0] hsize,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  input wire calib_halted_flag,
  input wire [7:0] fuse_gain_a,
  input wire [7:0] fuse_gain_b,
  input wire [3:0] fuse_bandgap,
  input wire [7:0] fuse_term_a,
  input wire eng_wr_en,
  input wire [9:0] eng_wr_index,
  input wire [7:0] eng_wr_data,
  input wire [9:0] eng_rd_index,
  output wire [7:0] eng_rd_data,
  output reg [7:0] gain_adjust_a,
  output reg [7:0] gain_adjust_b,
  output reg [3:0] bandgap_adjust,
  output reg [7:0] termination_adjust_a,
  output reg cal_access_en,
  output reg cal_vector_valid
);

  // --------------------------------------------------------------------
  // decode helpers
  // --------------------------------------------------------------------
  // an index reaches the vector port when access is on; with hold set the
  // streaming window behind the port also lands on it
  function is_port;
    input [7:0] idx;
    input en;
    input hold;
    begin
      is_port = en & ((idx == `CVT_IDX_CAL_PORT) |
        (hold & (idx >= `CVT_IDX_STREAM_LO) & (idx <= `CVT_IDX_STREAM_HI)));
    end
  endfunction

  function [7:0] trim_index;
    input integer k;
    begin
      case (k)
        `CVT_TRIM_GAIN_A: trim_index = `CVT_IDX_GAIN_A;
        `CVT_TRIM_GAIN_B: trim_index = `CVT_IDX_GAIN_B;
        `CVT_TRIM_BANDGAP: trim_index = `CVT_IDX_BANDGAP;
        default: trim_index = `CVT_IDX_TERM_A;
      endcase
    end
  endfunction

  // a write data phase that lands on the given register index
  function wr_hit;
    input stb;
    input [7:0] idx;
    input [7:0] target;
    begin
      wr_hit = stb & (idx == target);
    end
  endfunction

  // --------------------------------------------------------------------
  // bus front end
  // --------------------------------------------------------------------
  wire rd_stb;
  wire [7:0] rd_index;
  wire wr_stb;
  wire [7:0] wr_index;

  cvt_ahb_slave u_bus (
    .clk(clk),
    .rst(rst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready),
    .rd_stb(rd_stb),
    .rd_index(rd_index),
    .wr_stb(wr_stb),
    .wr_index(wr_index)
  );

  // --------------------------------------------------------------------
  // control state
  // --------------------------------------------------------------------
  reg hold_r;
  reg viol_r;
  reg [9:0] vec_idx_r;
  reg [9:0] vec_idx_nxt;
  reg [7:0] trim_r [0:`CVT_TRIM_NUM-1];
  wire [31:0] fuse_all;
  wire port_rd;
  wire port_wr;
  wire port_acc;
  wire en_wr;
  wire en_rise;
  wire ctrl_wr;
  wire status_clr;
  wire [7:0] vec_rdata;

  assign fuse_all = {fuse_term_a, `CVT_RST_NIBBLE, fuse_bandgap, fuse_gain_b, fuse_gain_a};
  assign port_rd = rd_stb & is_port(rd_index, cal_access_en, hold_r); // RL1 RL4 RL12
  assign port_wr = wr_stb & is_port(wr_index, cal_access_en, hold_r); // RL3 RL4 RL12
  // a read accepted in the same cycle as a port write steps only once
  assign port_acc = port_rd | port_wr;
  assign en_wr = wr_hit(wr_stb, wr_index, `CVT_IDX_CAL_EN);
  // writing 1 while already enabled leaves the index where it is
  assign en_rise = en_wr & hwdata[`CVT_EN_BIT] & ~cal_access_en;
  assign ctrl_wr = wr_hit(wr_stb, wr_index, `CVT_IDX_CTRL);
  assign status_clr = wr_hit(wr_stb, wr_index, `CVT_IDX_STATUS) & hwdata[`CVT_ST_VIOL];

  // --------------------------------------------------------------------
  // calibration vector store
  // --------------------------------------------------------------------
  // the host always addresses the slot under the vector index
  cvt_cal_store u_store (
    .clk(clk),
    .host_wr(port_wr),
    .host_index(vec_idx_r),
    .host_wdata(hwdata[7:0]),
    .host_rdata(vec_rdata),
    .eng_wr(eng_wr_en),
    .eng_wr_index(eng_wr_index),
    .eng_wr_data(eng_wr_data),
    .eng_rd_index(eng_rd_index),
    .eng_rd_data_r(eng_rd_data)
  );

  // --------------------------------------------------------------------
  // enable and address hold
  // --------------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      cal_access_en <= `CVT_RST_BIT;
    end else if (en_wr) begin
      cal_access_en <= hwdata[`CVT_EN_BIT]; // RL12
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      hold_r <= `CVT_RST_BIT;
    end else if (ctrl_wr) begin
      hold_r <= hwdata[`CVT_CTRL_HOLD]; // RL4
    end
  end

  // --------------------------------------------------------------------
  // vector index
  // --------------------------------------------------------------------
  always @* begin
    vec_idx_nxt = vec_idx_r;
    if (en_rise) begin
      vec_idx_nxt = `CVT_VEC_FIRST; // RL13
    end else if (port_acc) begin
      if (vec_idx_r == `CVT_VEC_LAST) begin
        vec_idx_nxt = `CVT_VEC_FIRST; // RL13 RL2
      end else begin
        vec_idx_nxt = vec_idx_r + 10'h001; // RL13 RL1 RL3
      end
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      vec_idx_r <= `CVT_VEC_FIRST;
    end else begin
      vec_idx_r <= vec_idx_nxt;
    end
  end

  // --------------------------------------------------------------------
  // vector validity and halted check
  // --------------------------------------------------------------------
  // the vector turns invalid as a sequence starts and valid once its last
  // slot is passed, so a sequence cut short leaves it invalid
  always @(posedge clk) begin
    if (rst) begin
      cal_vector_valid <= `CVT_RST_VALID;
    end else if (port_acc) begin
      if (vec_idx_r == `CVT_VEC_LAST) begin
        cal_vector_valid <= 1'h1; // RL6
      end else if (vec_idx_r == `CVT_VEC_FIRST) begin
        cal_vector_valid <= 1'h0; // RL6
      end
    end
  end

  // sticky record of port use while calibration runs; set beats clear
  always @(posedge clk) begin
    if (rst) begin
      viol_r <= `CVT_RST_BIT;
    end else if (port_acc && !calib_halted_flag) begin
      viol_r <= 1'h1; // RL5
    end else if (status_clr) begin
      viol_r <= 1'h0;
    end
  end

  // --------------------------------------------------------------------
  // trim registers
  // --------------------------------------------------------------------
  // reserved band-gap bits 7:4 are stored but never reach the output
  genvar k;
  generate
    for (k = 0; k < `CVT_TRIM_NUM; k = k + 1) begin : g_trim
      wire hit;
      assign hit = wr_hit(wr_stb, wr_index, trim_index(k));
      always @(posedge clk) begin
        if (rst) begin
          trim_r[k] <= fuse_all[8*k +: 8]; // RL8 RL9 RL10 RL11
        end else if (hit) begin
          trim_r[k] <= hwdata[7:0]; // RL8 RL9 RL10 RL11
        end
      end
    end
  endgenerate

  // trim outputs follow the stored values one cycle later
  always @(posedge clk) begin
    if (rst) begin
      gain_adjust_a <= fuse_gain_a;
      gain_adjust_b <= fuse_gain_b;
      bandgap_adjust <= fuse_bandgap;
      termination_adjust_a <= fuse_term_a;
    end else begin
      gain_adjust_a <= trim_r[`CVT_TRIM_GAIN_A]; // RL8
      gain_adjust_b <= trim_r[`CVT_TRIM_GAIN_B]; // RL9
      bandgap_adjust <= trim_r[`CVT_TRIM_BANDGAP][3:0]; // RL10
      termination_adjust_a <= trim_r[`CVT_TRIM_TERM_A]; // RL11
    end
  end

  // --------------------------------------------------------------------
  // read data and response
  // --------------------------------------------------------------------
  reg [31:0] rd_word;

  always @* begin
    rd_word = 32'h00000000;
    // the port shows the slot under the index; the index steps at the same edge
    if (port_rd) begin
      rd_word = {24'h000000, vec_rdata}; // RL1 RL7
    end else begin
      case (rd_index)
        `CVT_IDX_CAL_EN: rd_word = {31'h00000000, cal_access_en};
        `CVT_IDX_CAL_PORT: rd_word = 32'h00000000; // RL12
        `CVT_IDX_GAIN_A: rd_word = {24'h000000, trim_r[`CVT_TRIM_GAIN_A]};
        `CVT_IDX_GAIN_B: rd_word = {24'h000000, trim_r[`CVT_TRIM_GAIN_B]};
        `CVT_IDX_BANDGAP: rd_word = {24'h000000, trim_r[`CVT_TRIM_BANDGAP]};
        `CVT_IDX_TERM_A: rd_word = {24'h000000, trim_r[`CVT_TRIM_TERM_A]};
        `CVT_IDX_STATUS: rd_word = {29'h00000000, viol_r, cal_vector_valid,
          calib_halted_flag};
        `CVT_IDX_CTRL: rd_word = {31'h00000000, hold_r};
        `CVT_IDX_VEC_INDEX: rd_word = {22'h000000, vec_idx_r};
        default: rd_word = 32'h00000000;
      endcase
    end
  end

  // zero wait states: data is captured as the address phase is taken
  always @(posedge clk) begin
    if (rst) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'h1;
      hresp <= 1'h0;
    end else begin
      hreadyout <= 1'h1;
      hresp <= 1'h0;
      if (rd_stb) begin
        hrdata <= rd_word;
      end
    end
  end

endmodule

// File: hdl/cvt_defines.vh
// register indices, field positions and reset values of the calibration
// vector and trim register bank.
// assumes byte address = 4 * index on a 32-bit AHB-Lite bus.
`ifndef CVT_DEFINES_VH
`define CVT_DEFINES_VH

// ----------------------------------------------------------------------
// register indices
// ----------------------------------------------------------------------
`define CVT_IDX_CAL_EN 8'h70
`define CVT_IDX_CAL_PORT 8'h71
`define CVT_IDX_STREAM_LO 8'h72
`define CVT_IDX_STREAM_HI 8'h79
`define CVT_IDX_GAIN_A 8'h7A
`define CVT_IDX_GAIN_B 8'h7B
`define CVT_IDX_BANDGAP 8'h7C
`define CVT_IDX_TERM_A 8'h7E
`define CVT_IDX_STATUS 8'h80
`define CVT_IDX_CTRL 8'h81
`define CVT_IDX_VEC_INDEX 8'h82
`define CVT_IDX_NONE 8'hFF

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define CVT_EN_BIT 0
`define CVT_ST_HALTED 0
`define CVT_ST_VALID 1
`define CVT_ST_VIOL 2
`define CVT_CTRL_HOLD 0
`define CVT_TRIM_NUM 4
`define CVT_TRIM_GAIN_A 0
`define CVT_TRIM_GAIN_B 1
`define CVT_TRIM_BANDGAP 2
`define CVT_TRIM_TERM_A 3

// ----------------------------------------------------------------------
// vector size and reset values
// ----------------------------------------------------------------------
`define CVT_VEC_LEN 673
`define CVT_IDX_W 10
`define CVT_VEC_FIRST 10'h000
`define CVT_VEC_LAST 10'h2A0
`define CVT_RST_BYTE 8'h00
`define CVT_RST_NIBBLE 4'h0
`define CVT_RST_VALID 1'h1
`define CVT_RST_BIT 1'h0
`define CVT_HTRANS_NONSEQ 2'h2

`endif

// File: hdl/cvt_ahb_slave.v
// AHB-Lite address and data phase tracking for the trim register bank.
// assumes a single slave on the bus, so hready is this slave's hreadyout.
`timescale 1ns/1ns
`include "cvt_defines.vh"

module cvt_ahb_slave (
  input wire clk,
  input wire rst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  output wire rd_stb,
  output wire [7:0] rd_index,
  output wire wr_stb,
  output wire [7:0] wr_index
);

  // --------------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------------
  wire addr_phase;
  wire [7:0] addr_index;
  reg wr_pend_r;
  reg [7:0] wr_index_r;

  // both NONSEQ and SEQ carry a transfer; anything above the map is unmapped
  assign addr_phase = hsel & htrans[1] & hready;
  assign addr_index = (haddr[31:10] == 22'h000000) ? haddr[9:2] : `CVT_IDX_NONE;

  assign rd_stb = addr_phase & ~hwrite;
  assign rd_index = addr_index;
  // write data is taken at the end of the data phase
  assign wr_stb = wr_pend_r & hready;
  assign wr_index = wr_index_r;

  // --------------------------------------------------------------------
  // data phase state
  // --------------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      wr_pend_r <= 1'h0;
      wr_index_r <= `CVT_IDX_NONE;
    end else if (hready) begin
      wr_pend_r <= addr_phase & hwrite;
      wr_index_r <= addr_index;
    end
  end

endmodule

// File: hdl/cvt_cal_store.v
// storage for the calibration vector of the converter cores.
// assumes the calibration engine and the host port never write in the same
// cycle; the host write wins and the engine write is dropped if they do.
`timescale 1ns/1ns
`include "cvt_defines.vh"

module cvt_cal_store (
  input wire clk,
  input wire host_wr,
  input wire [9:0] host_index,
  input wire [7:0] host_wdata,
  output wire [7:0] host_rdata,
  input wire eng_wr,
  input wire [9:0] eng_wr_index,
  input wire [7:0] eng_wr_data,
  input wire [9:0] eng_rd_index,
  output reg [7:0] eng_rd_data_r
);

  // --------------------------------------------------------------------
  // vector memory, no reset: contents undefined until loaded
  // --------------------------------------------------------------------
  reg [7:0] mem [0:`CVT_VEC_LEN-1];

  assign host_rdata = (host_index <= `CVT_VEC_LAST) ? mem[host_index] : `CVT_RST_BYTE;

  always @(posedge clk) begin
    if (host_wr && host_index <= `CVT_VEC_LAST) begin
      mem[host_index] <= host_wdata;
    end else if (eng_wr && eng_wr_index <= `CVT_VEC_LAST) begin
      mem[eng_wr_index] <= eng_wr_data;
    end
  end

  // --------------------------------------------------------------------
  // engine read port
  // --------------------------------------------------------------------
  always @(posedge clk) begin
    if (eng_rd_index <= `CVT_VEC_LAST) begin
      eng_rd_data_r <= mem[eng_rd_index];
    end else begin
      eng_rd_data_r <= `CVT_RST_BYTE;
    end
  end

endmodule

// File: dv/cvt_regs_sva.sv
// checker for the calibration vector and trim register bank.
// assumes hready is looped back from hreadyout.
`timescale 1ns/1ns
`include "cvt_defines.vh"
module cvt_regs_chk (
  input logic clk,
  input logic rst,
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [31:0] hwdata,
  input logic hready,
  input logic hreadyout,
  input logic hresp,
  input logic [31:0] hrdata,
  input logic [7:0] fuse_gain_a,
  input logic [3:0] fuse_bandgap,
  input logic [7:0] gain_adjust_a,
  input logic [3:0] bandgap_adjust,
  input logic cal_access_en,
  input logic cal_vector_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_req(logic wr, logic [7:0] idx);
    hsel && htrans[1] && hready && hwrite == wr && haddr == {22'h0, idx, 2'h0};
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
  a_reset_trim: assert property ($fell(rst) |->
    gain_adjust_a == $past(fuse_gain_a) && bandgap_adjust == $past(fuse_bandgap))
    else $error("trim not fuse value after reset");
  a_reset_flags: assert property ($fell(rst) |-> cal_vector_valid && !cal_access_en)
    else $error("flags wrong after reset");
  a_gain_wr: assert property (s_req(1'b1, `CVT_IDX_GAIN_A) |-> ##1 hready ##2
    {24'h0, gain_adjust_a} == ($past(hwdata, 2) & 32'h000000FF))
    else $error("gain a output did not follow write");
  a_bandgap_wr: assert property (s_req(1'b1, `CVT_IDX_BANDGAP) |-> ##1 hready ##2
    {28'h0, bandgap_adjust} == ($past(hwdata, 2) & 32'h0000000F))
    else $error("bandgap output did not follow write");
  a_port_gated: assert property (s_req(1'b0, `CVT_IDX_CAL_PORT) ##0 !cal_access_en
    |=> hrdata == 32'h0) else $error("port read while disabled not zero");
  a_gap_zero: assert property (s_req(1'b0, 8'h7D) |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_rd_hold: assert property (!(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
    else $error("read data changed without read");
  a_trim_read: assert property (s_req(1'b0, `CVT_IDX_GAIN_A) |=>
    hrdata == {24'h0, gain_adjust_a}) else $error("gain a readback differs from output");
endmodule

bind cvt_regs cvt_regs_chk u_chk (
  .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .fuse_gain_a(fuse_gain_a), .fuse_bandgap(fuse_bandgap), .gain_adjust_a(gain_adjust_a),
  .bandgap_adjust(bandgap_adjust), .cal_access_en(cal_access_en),
  .cal_vector_valid(cal_vector_valid)
);

// File: dv/testbench.sv
// self-checking bench for the calibration vector and trim register bank.
// assumes hready is looped back from hreadyout; the engine reads slot 5 and writes slot 9 once.
`timescale 1ns/1ns
`include "cvt_defines.vh"
module testbench;
  logic clk, rst, hsel, hwrite, halted, eng_we;
  logic [31:0] haddr, hwdata, rnd, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] fga, fgb, fta, eng_wd;
  logic [3:0] fbg;
  logic [9:0] eng_wi, eng_ri;
  wire hreadyout, hresp, en, valid;
  wire [31:0] hrdata;
  wire [7:0] ga, gb, ta, eng_rd;
  wire [3:0] bg;
  wire [31:0] touts = {ta, 4'h0, bg, gb, ga};
  logic [7:0] tix [4] = '{`CVT_IDX_GAIN_A, `CVT_IDX_GAIN_B, `CVT_IDX_BANDGAP, `CVT_IDX_TERM_A};
  logic [7:0] tm [4];
  logic [7:0] q [$];
  int err_count, checked, i;

  cvt_regs dut (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hsize(hsize),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .calib_halted_flag(halted), .fuse_gain_a(fga),
    .fuse_gain_b(fgb), .fuse_bandgap(fbg), .fuse_term_a(fta), .eng_wr_en(eng_we),
    .eng_wr_index(eng_wi), .eng_wr_data(eng_wd), .eng_rd_index(eng_ri),
    .eng_rd_data(eng_rd), .gain_adjust_a(ga), .gain_adjust_b(gb), .bandgap_adjust(bg),
    .termination_adjust_a(ta), .cal_access_en(en), .cal_vector_valid(valid)
  );

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // waits for an edge with hready high, bounded
  task automatic edge_ready();
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 20) begin
        err_count++;
        end_of_test();
      end
      @(posedge clk);
    end
  endtask

  // one word transfer, then one idle cycle
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'h0};
    htrans <= `CVT_HTRANS_NONSEQ;
    hwrite <= wr;
    edge_ready();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    edge_ready();
    rd = hrdata;
    @(posedge clk);
  endtask

  // ----------------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    end_of_test();
  end

  initial begin
    err_count = 0;
    checked = 0;
    rnd = 32'h18A3C074;
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    hwrite = 1'b0;
    hwdata = 32'h0;
    halted = 1'b1;
    eng_we = 1'b0;
    eng_wi = 10'h0;
    eng_wd = 8'h0;
    eng_ri = 10'h0;
    {fta, fbg, fgb, fga} = rnd[27:0];
    tm = '{fga, fgb, {4'h0, fbg}, fta};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (i = 0; i < 4; i++) begin
      bus(1'b0, tix[i], 32'h0);
      chk("trim reset", {24'h0, tm[i]}, rd);
    end
    chk("valid reset", 32'h1, {31'h0, valid});
    $display("test reset done");
    for (i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      tm[i] = rnd[7:0];
      bus(1'b1, tix[i], rnd);
      bus(1'b0, tix[i], 32'h0);
      chk("trim rw", {24'h0, tm[i]}, rd);
    end
    @(negedge clk);
    chk("trim out", {tm[3], 4'h0, tm[2][3:0], tm[1], tm[0]}, touts);
    @(posedge clk);
    $display("test trims done");
    bus(1'b1, `CVT_IDX_CAL_PORT, 32'h5A);
    bus(1'b0, `CVT_IDX_CAL_PORT, 32'h0);
    chk("port gated", 32'h0, rd);
    bus(1'b0, 8'h7D, 32'h0);
    chk("gap", 32'h0, rd);
    bus(1'b1, `CVT_IDX_CAL_EN, 32'h1);
    for (i = 0; i < `CVT_VEC_LEN; i++) begin
      rnd = lfsr(rnd);
      q.push_back(rnd[7:0]);
      bus(1'b1, `CVT_IDX_CAL_PORT, {24'h0, rnd[7:0]});
      if (i == 0) begin
        chk("valid early", 32'h0, {31'h0, valid});
      end
    end
    chk("valid full", 32'h1, {31'h0, valid});
    eng_ri <= 10'h005;
    repeat (2) @(posedge clk);
    chk("slot 5", {24'h0, q[5]}, {24'h0, eng_rd});
    eng_wi <= 10'h009;
    eng_wd <= ~q[9];
    eng_we <= 1'b1;
    @(posedge clk);
    eng_we <= 1'b0;
    q[9] = ~q[9];
    bus(1'b1, `CVT_IDX_CTRL, 32'h1);
    bus(1'b1, `CVT_IDX_CAL_EN, 32'h0);
    bus(1'b1, `CVT_IDX_CAL_EN, 32'h1);
    for (i = 0; i < `CVT_VEC_LEN; i++) begin
      bus(1'b0, `CVT_IDX_CAL_PORT + 8'(i % 9), 32'h0);
      chk("vector", {24'h0, q[i]}, rd);
    end
    chk("valid read", 32'h1, {31'h0, valid});
    bus(1'b0, `CVT_IDX_CAL_PORT, 32'h0);
    chk("wrap", {24'h0, q[0]}, rd);
    bus(1'b1, `CVT_IDX_CTRL, 32'h0);
    bus(1'b0, `CVT_IDX_STREAM_LO, 32'h0);
    chk("alias off", 32'h0, rd);
    $display("test vector done");
    bus(1'b1, `CVT_IDX_CAL_EN, 32'h0);
    bus(1'b1, `CVT_IDX_CAL_EN, 32'h1);
    repeat (3) bus(1'b0, `CVT_IDX_CAL_PORT, 32'h0);
    bus(1'b0, `CVT_IDX_VEC_INDEX, 32'h0);
    chk("index", 32'h3, rd);
    halted <= 1'b0;
    bus(1'b0, `CVT_IDX_CAL_PORT, 32'h0);
    bus(1'b0, `CVT_IDX_STATUS, 32'h0);
    chk("status", 32'h4, rd);
    halted <= 1'b1;
    bus(1'b1, `CVT_IDX_STATUS, 32'h4);
    bus(1'b0, `CVT_IDX_STATUS, 32'h0);
    chk("status clear", 32'h1, rd);
    $display("test status done");
    end_of_test();
  end
endmodule
